// >>> hdl/nvc_host.sv
// What this block does
// - Store sends 84h then A5h
// - Setting volatile; software store to keep
// - Enable/disable issued only when ready
// - Protect pin steady; idle settle after change
// - Request pin held high normally
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"
module nvc_host
   import nvc_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [7:0] dq_o,
   output logic dq_oe_n_o,
   input wire logic [7:0] dq_i,
   output logic cle_o,
   output logic ale_o,
   output logic ce_n_o,
   output logic we_n_o,
   output logic re_n_o,
   output logic wp_n_o,
   output logic hsb_o,
   output logic hsb_oe_n_o,
   input wire logic hsb_i,
   input wire logic rb_i
);
   localparam logic [7:0] STROBE_CYC = 8'(`NVC_STROBE_CYC);
   localparam logic [7:0] WW_CYC = 8'(`NVC_WW_CYC);
   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   nvc_pin_if pin ();
   assign pin.rb_raw = rb_i;
   nvc_sync u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin(pin)
   );
   logic rb;
   assign rb = pin.rb_sync;
   // ------------------------------------------------------------
   // Registers and sequencer
   // ------------------------------------------------------------
   nvc_state_t state, next_state;
   logic [7:0] cmd, next_cmd;
   logic rd, next_rd;
   logic wp, next_wp;
   logic hw_save_request_pin, next_hsb;
   logic [7:0] cnt, next_cnt;
   logic [7:0] rdat, next_rdat;
   logic ack, next_ack;
   logic cle, next_cle;
   logic we_n, next_we_n;
   logic re_n, next_re_n;
   logic two, next_two;
   logic err, next_err;
   logic dirty, next_dirty;
   logic hsb_meta, next_hsb_meta;
   logic hsb_sync, next_hsb_sync;
   logic hit_ctrl, hit_stat, wr_go;
   function automatic logic is_pair(input logic [7:0] c);
      return c == `NVC_CMD_STORE1;
   endfunction : is_pair
   function automatic logic needs_ready(input logic [7:0] c);
      return !(c == `NVC_CMD_RESET || c == `NVC_CMD_STATUS);
   endfunction : needs_ready
   assign hit_ctrl = wb_adr_i == `NVC_OFF_CTRL;
   assign hit_stat = wb_adr_i == `NVC_OFF_STAT;
   assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack && hit_ctrl && wb_sel_i[1]
      && wb_dat_i[`NVC_CTRL_GO];
   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_rd = rd;
      next_wp = wp;
      next_hsb = hw_save_request_pin;
      next_cnt = cnt;
      next_rdat = rdat;
      next_cle = cle;
      next_we_n = we_n;
      next_re_n = re_n;
      next_two = two;
      next_err = err;
      next_dirty = dirty;
      next_hsb_meta = hsb_i;
      next_hsb_sync = hsb_meta;
      next_ack = wb_cyc_i && wb_stb_i && !ack;
      if (wr_go && state == NVC_IDLE) begin
         next_err = 1'b0;
         if (needs_ready(wb_dat_i[7:0]) && !rb) begin
            next_err = 1'b1;
         end else if (wb_dat_i[`NVC_CTRL_WP] != wp) begin
            next_wp = wb_dat_i[`NVC_CTRL_WP];
            next_cnt = WW_CYC;
            next_state = NVC_SETTLE;
         end else begin
            next_cmd = wb_dat_i[7:0];
            next_rd = wb_dat_i[7:0] == `NVC_CMD_STATUS;
            next_two = is_pair(wb_dat_i[7:0]);
            next_state = NVC_SETUP;
            next_dirty = (dirty && !is_pair(wb_dat_i[7:0])) || wb_dat_i[7:0] == `NVC_CMD_PLS_OFF
               || wb_dat_i[7:0] == `NVC_CMD_PLS_ON;
         end
      end else if (wr_go && hit_ctrl) begin
         next_err = 1'b1;
      end
      if (wb_cyc_i && wb_stb_i && wb_we_i && !ack && hit_ctrl && wb_sel_i[1]
         && state == NVC_IDLE) begin
         next_hsb = wb_dat_i[`NVC_CTRL_HSB];
      end
      case (state)
         NVC_IDLE: begin
         end
         NVC_SETUP: begin
            next_cle = 1'b1;
            next_we_n = 1'b0;
            next_cnt = STROBE_CYC;
            next_state = NVC_LOW;
         end
         NVC_LOW: begin
            if (cnt > 8'h01) begin
               next_cnt = cnt - 8'h01;
            end else begin
               next_we_n = 1'b1;
               next_cnt = STROBE_CYC;
               next_state = NVC_HIGH;
            end
         end
         NVC_HIGH: begin
            if (cnt > 8'h01) begin
               next_cnt = cnt - 8'h01;
            end else if (two) begin
               next_two = 1'b0;
               next_cmd = `NVC_CMD_STORE2;
               next_state = NVC_SETUP;
            end else if (rd) begin
               next_cle = 1'b0;
               next_re_n = 1'b0;
               next_rd = 1'b0;
               next_cnt = STROBE_CYC;
               next_state = NVC_LOW;
            end else begin
               next_cle = 1'b0;
               if (!re_n) begin
                  next_rdat = dq_i;
               end
               next_re_n = 1'b1;
               next_cnt = 8'h04;
               next_state = NVC_WAITRB;
            end
         end
         NVC_WAITRB: begin
            if (cnt != 8'h00) begin
               next_cnt = cnt - 8'h01;
            end else if (rb) begin
               next_state = NVC_IDLE;
            end
         end
         NVC_SETTLE: begin
            if (cnt > 8'h01) begin
               next_cnt = cnt - 8'h01;
            end else begin
               next_state = NVC_IDLE;
            end
         end
         default: begin
            next_state = NVC_IDLE;
         end
      endcase
      if (state == NVC_LOW && rd == 1'b0 && !re_n && cnt == 8'h01) begin
         next_re_n = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state <= NVC_IDLE;
         cmd <= 8'h00;
         rd <= 1'b0;
         wp <= 1'b1;
         hw_save_request_pin <= 1'b1;
         cnt <= 8'h00;
         rdat <= 8'h00;
         ack <= 1'b0;
         cle <= 1'b0;
         we_n <= 1'b1;
         re_n <= 1'b1;
         two <= 1'b0;
         err <= 1'b0;
         dirty <= 1'b0;
         hsb_meta <= 1'b1;
         hsb_sync <= 1'b1;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         rd <= next_rd;
         wp <= next_wp;
         hw_save_request_pin <= next_hsb;
         cnt <= next_cnt;
         rdat <= next_rdat;
         ack <= next_ack;
         cle <= next_cle;
         we_n <= next_we_n;
         re_n <= next_re_n;
         two <= next_two;
         err <= next_err;
         dirty <= next_dirty;
         hsb_meta <= next_hsb_meta;
         hsb_sync <= next_hsb_sync;
      end
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_o = ack;
   always_comb begin
      wb_dat_o = 32'h0000_0000;
      if (hit_stat) begin
         wb_dat_o = {27'h0000000, dirty, err, hsb_sync, rb, state == NVC_IDLE};
      end else if (wb_adr_i == `NVC_OFF_RDAT) begin
         wb_dat_o = {24'h000000, rdat};
      end else if (hit_ctrl) begin
         wb_dat_o = {21'h000000, hw_save_request_pin, wp, 1'b0, cmd};
      end
   end
   assign dq_o = cmd;
   assign dq_oe_n_o = !(state == NVC_SETUP || (state == NVC_LOW && re_n)
      || (state == NVC_HIGH && re_n && cle));
   assign cle_o = cle;
   assign ale_o = 1'b0;
   assign ce_n_o = state == NVC_IDLE || state == NVC_SETTLE;
   assign we_n_o = we_n;
   assign re_n_o = re_n;
   assign wp_n_o = wp;
   assign hsb_o = 1'b0;
   assign hsb_oe_n_o = hw_save_request_pin;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_store_first;
      state == NVC_HIGH && cmd == `NVC_CMD_STORE1 && cnt == 8'h01;
   endsequence
   a_store_second: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_store_first |=> cmd == `NVC_CMD_STORE2)
      else $error("second store byte missing");
   a_busy_refuse: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_go && state == NVC_IDLE && !rb && needs_ready(wb_dat_i[7:0]))
      |=> err && state == NVC_IDLE)
      else $error("command issued while busy");
   a_wait_ready: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state == NVC_WAITRB && cnt == 8'h00 && !rb) |=> state == NVC_WAITRB)
      else $error("left wait while busy");
   a_wp_settle: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $changed(wp) |-> state == NVC_SETTLE ##1 state == NVC_SETTLE)
      else $error("no settle after protect change");
   a_hsb_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
      state != NVC_IDLE |=> $stable(hw_save_request_pin))
      else $error("request pin moved mid command");
endmodule : nvc_host
`default_nettype wire

// >>> inc/nvc_defs.svh
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH
// Register offsets (byte addresses)
`define NVC_OFF_CTRL 8'h00
`define NVC_OFF_STAT 8'h04
`define NVC_OFF_RDAT 8'h08
// Control fields
`define NVC_CTRL_GO 8
`define NVC_CTRL_WP 9
`define NVC_CTRL_HSB 10
// Command codes
`define NVC_CMD_STORE1 8'h84
`define NVC_CMD_STORE2 8'ha5
`define NVC_CMD_PLS_OFF 8'ha3
`define NVC_CMD_PLS_ON 8'hac
`define NVC_CMD_RECALL 8'hfc
`define NVC_CMD_STATUS 8'h70
`define NVC_CMD_RESET 8'hff
`define NVC_CMD_WRITE 8'h80
// Status fields
`define NVC_SR_READY 6
`define NVC_SR_WPOK 7
// Timing
`define NVC_CLK_MHZ 20
`define NVC_STROBE_NS 100
`define NVC_STROBE_CYC ((`NVC_STROBE_NS * `NVC_CLK_MHZ + 999) / 1000)
`define NVC_WW_NS 1000
`define NVC_WW_CYC ((`NVC_WW_NS * `NVC_CLK_MHZ + 999) / 1000)
`endif

// >>> inc/nvc_pkg.sv
package nvc_pkg;
   typedef enum logic [5:0] {
      NVC_IDLE = 6'b000001,
      NVC_SETUP = 6'b000010,
      NVC_LOW = 6'b000100,
      NVC_HIGH = 6'b001000,
      NVC_WAITRB = 6'b010000,
      NVC_SETTLE = 6'b100000
   } nvc_state_t;
endpackage : nvc_pkg

// >>> inc/nvc_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nvc_pin_if;
   logic rb_raw;
   logic rb_sync;
   modport sync (input rb_raw, output rb_sync);
   modport user (output rb_raw, input rb_sync);
endinterface : nvc_pin_if
`default_nettype wire

// >>> hdl/nvc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nvc_sync
   import nvc_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   nvc_pin_if.sync pin
);
   logic meta;
   logic next_meta;
   logic stable;
   logic next_stable;
   always_comb begin
      next_meta = pin.rb_raw;
      next_stable = meta;
   end
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta <= 1'b0; // Busy until pin is seen
         stable <= 1'b0;
      end else begin
         meta <= next_meta;
         stable <= next_stable;
      end
   end
   assign pin.rb_sync = stable;
endmodule : nvc_sync
`default_nettype wire

// >>> test/nvc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"
module nvc_dev_model (
   input wire logic clk_i,
   input wire logic cle_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic re_n_i,
   input wire logic wp_n_i,
   input wire logic hsb_drv_i,
   input wire logic hsb_oe_n_i,
   input wire logic [7:0] cmd_i,
   output logic [7:0] dq_o,
   output logic hsb_pin_o,
   output logic rb_o
);
   // ----------------------------------------
   // Device state
   // ----------------------------------------
   int busy = 60;
   int store_cnt = 0;
   int recall_cnt = 0;
   logic pls_en = 1'b1;
   logic wp_ok = 1'b1;
   logic wrote = 1'b0;
   logic pend_rst = 1'b0;
   logic we_q = 1'b1;
   logic hsb_q = 1'b1;
   logic [7:0] prev = 8'h00;
   logic [7:0] sr;
   assign hsb_pin_o = hsb_oe_n_i ? 1'b1 : hsb_drv_i;
   assign rb_o = !(busy != 0 || !hsb_pin_o);
   assign sr = {wp_ok, rb_o, 6'h00};
   assign dq_o = (!ce_n_i && !re_n_i) ? sr : ~sr;
   always @(posedge clk_i) begin
      we_q <= we_n_i;
      hsb_q <= hsb_pin_o;
      if (busy > 0) busy <= busy - 1;
      if (busy == 1 && pend_rst) pend_rst <= 1'b0;
      if (hsb_q && !hsb_pin_o && wrote) begin
         store_cnt <= store_cnt + 1;
         wrote <= 1'b0;
      end
      if (we_n_i && !we_q && !ce_n_i && cle_i) begin
         prev <= cmd_i;
         if (cmd_i == `NVC_CMD_RESET) pend_rst <= (busy != 0);
         else if (busy == 0 && hsb_pin_o) begin
            if (cmd_i == `NVC_CMD_STORE2 && prev == `NVC_CMD_STORE1) begin
               store_cnt <= store_cnt + 1;
               wrote <= 1'b0;
               busy <= 40;
            end
            if (cmd_i == `NVC_CMD_PLS_OFF || cmd_i == `NVC_CMD_PLS_ON) begin
               pls_en <= (cmd_i == `NVC_CMD_PLS_ON);
               busy <= 10;
            end
            if (cmd_i == `NVC_CMD_RECALL) begin
               recall_cnt <= recall_cnt + 1;
               wrote <= 1'b0;
               busy <= 20;
            end
            if (cmd_i == `NVC_CMD_WRITE) begin
               wp_ok <= wp_n_i;
               if (wp_n_i) wrote <= 1'b1;
            end
         end
      end
   end
endmodule : nvc_dev_model
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.svh"
module tb;
   import nvc_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] q;
   logic [31:0] rdat;
   logic ack;
   logic [7:0] dq_o, dq_i;
   logic dq_oe_n, cle, ce_n, we_n, re_n, wp_n, hsb_o, hsb_oe_n, hsb_pin, rb;
   int n_errors = 0;
   int cmp_count = 0;
   nvc_host dut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
      .wb_ack_o(ack), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n), .dq_i(dq_i), .cle_o(cle),
      .ale_o(), .ce_n_o(ce_n), .we_n_o(we_n), .re_n_o(re_n), .wp_n_o(wp_n),
      .hsb_o(hsb_o), .hsb_oe_n_o(hsb_oe_n), .hsb_i(hsb_pin), .rb_i(rb));
   nvc_dev_model dev (.clk_i(clk_i), .cle_i(cle), .ce_n_i(ce_n), .we_n_i(we_n),
      .re_n_i(re_n), .wp_n_i(wp_n), .hsb_drv_i(hsb_o), .hsb_oe_n_i(hsb_oe_n),
      .cmd_i(dq_o), .dq_o(dq_i), .hsb_pin_o(hsb_pin), .rb_o(rb));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic finish_test();
      if (n_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic poll();
      do begin
         wb(1'b0, `NVC_OFF_STAT, 32'h0);
      end while (q[0] !== 1'b1);
   endtask : poll
   task automatic go(input logic [7:0] c, input logic [1:0] hw);
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, hw, 1'b1, c});
      poll();
   endtask : go
   initial begin
      #1000000;
      n_errors++;
      finish_test();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      wb(1'b0, `NVC_OFF_STAT, 32'h0);
      check("restore_busy", {31'h0, q[1]}, 32'h0);
      do begin
         wb(1'b0, `NVC_OFF_STAT, 32'h0);
      end while (q[1] !== 1'b1);
      check("stat", {28'h0, q[3:0]}, 32'h7);
      check("pls_default", {31'h0, dev.pls_en}, 32'h1);
      go(`NVC_CMD_STORE1, 2'b11);
      check("store", dev.store_cnt, 1);
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b11, 1'b1, `NVC_CMD_STORE1});
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b11, 1'b1, `NVC_CMD_STATUS});
      wb(1'b0, `NVC_OFF_STAT, 32'h0);
      check("refuse", {31'h0, q[3]}, 32'h1);
      poll();
      check("store2", dev.store_cnt, 2);
      go(`NVC_CMD_STATUS, 2'b11);
      wb(1'b0, `NVC_OFF_RDAT, 32'h0);
      check("status", {24'h0, q[7:0]}, 32'hc0);
      go(`NVC_CMD_PLS_OFF, 2'b11);
      check("pls_off", {31'h0, dev.pls_en}, 32'h0);
      go(`NVC_CMD_PLS_ON, 2'b11);
      check("pls_on", {31'h0, dev.pls_en}, 32'h1);
      wb(1'b0, `NVC_OFF_STAT, 32'h0);
      check("pls_unsaved", {31'h0, q[4]}, 32'h1);
      go(`NVC_CMD_RECALL, 2'b11);
      check("recall", dev.recall_cnt, 1);
      // No write yet, so a request pin pulse must not save
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b01, 9'h0});
      repeat (4) @(posedge clk_i);
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b11, 9'h0});
      check("hsb_skip", dev.store_cnt, 2);
      go(`NVC_CMD_WRITE, 2'b10);
      go(`NVC_CMD_WRITE, 2'b10);
      go(`NVC_CMD_STATUS, 2'b10);
      wb(1'b0, `NVC_OFF_RDAT, 32'h0);
      check("protect", {24'h0, q[7:0]}, 32'h40);
      go(`NVC_CMD_WRITE, 2'b11);
      go(`NVC_CMD_WRITE, 2'b11);
      check("unprotect", {31'h0, dev.wp_ok}, 32'h1);
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b01, 9'h0});
      repeat (4) @(posedge clk_i);
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b01, 1'b1, `NVC_CMD_PLS_OFF});
      wb(1'b0, `NVC_OFF_STAT, 32'h0);
      check("hsb_busy", {30'h0, q[2:1]}, 32'h0);
      check("busy_refuse", {31'h0, q[3]}, 32'h1);
      check("pls_kept", {31'h0, dev.pls_en}, 32'h1);
      check("hsb_store", dev.store_cnt, 3);
      wb(1'b1, `NVC_OFF_CTRL, {21'h0, 2'b11, 9'h0});
      poll();
      check("hsb_free", {30'h0, q[2:1]}, 32'h3);
      finish_test();
   end
endmodule : tb
`default_nettype wire
